// File: osc_pm_pkg.sv
// constants, types and register map of the clock monitor and power-mode block
package osc_pm_pkg;

  // register map: printed offsets are indices, byte address is index times four
  localparam logic [7:0]  POWER_MODE_CONTROL_IDX   = 8'h87;
  localparam logic [7:0]  STAT_IDX   = 8'h88;
  localparam logic [11:0] POWER_MODE_CONTROL_ADDR  = {2'h0, POWER_MODE_CONTROL_IDX, 2'h0};
  localparam logic [11:0] STAT_ADDR  = {2'h0, STAT_IDX, 2'h0};
  localparam logic [7:0]  POWER_MODE_CONTROL_RESET = 8'h00;

  // power_mode_control field positions
  localparam int IDLE_ARM_BIT    = 0;
  localparam int DEEP_ARM_BIT    = 1;
  localparam int SPARE_A_BIT     = 2;
  localparam int SPARE_B_BIT     = 3;
  localparam int LIGHT_START_BIT = 5;
  localparam int DEEP_START_BIT  = 6;
  localparam int BAUD_BIT        = 7;

  // status register field positions
  localparam int OSC_FLAG_BIT  = 0;
  localparam int TOUT_FLAG_BIT = 1;
  localparam int RC_SEL_BIT    = 2;
  localparam int OSC_RST_BIT   = 3;

  // reference divider and timing
  localparam logic [2:0] REF_DIV_LAST   = 3'h4;        // divide by five: 0..4
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         SETTLE_TIME_NS = 1000000;     // final reset phase, 1 ms
  localparam int         SETTLE_CYCLES  = SETTLE_TIME_NS / CLK_PERIOD_NS;
  localparam int         POWERON_MAX_NS = 34000;       // power-on to reset state
  localparam int         POWERON_CYCLES = POWERON_MAX_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {MON_FAIL, MON_SETTLE, MON_RUN} mon_state_t;
  typedef enum logic [1:0] {PM_ACTIVE, PM_IDLE, PM_DOWN} pm_state_t;

  // clock gating and pin control towards the core
  typedef struct packed {
    logic cpu_clk_en;    // low in idle and power-down
    logic periph_clk_en; // low in power-down
    logic osc_run;       // low in power-down
    logic port_hold;     // latch-driven pins hold their level
    logic strobe_force;  // address latch and code read strobe forced
    logic strobe_level;  // forced level: high in idle, low in power-down
  } sleep_ctrl_t;

endpackage

// File: osc_monitor_power_modes.sv
// oscillator monitor, reset control and power-mode register with apb access
//
// Contract
// [R1] fail when oscillator edges fall short of rc reference divided by five
// [R2] on failure the core clock selects the rc source
// [R3] reset is asserted together with the switch to rc clock
// [R4] monitor reset keeps timeout flag, stops watchdog, sets failure flag
// [R5] on recovery hold reset and rc clock for a 1 ms settle phase
// [R6] after settling select oscillator clock and drop the reset request
// [R7] chip reset stays while external reset stays asserted
// [R8] software sets and clears failure flag; external reset clears both flags
// [R9] at power-on start in failure with rc clock and reset within 34 us
// [R10] simultaneous idle and power-down requests enter power-down
// [R11] power-down arm at bit 1, start at bit 6
// [R12] idle arm at bit 0, start at bit 5
// [R13] spare flags at bits 3 and 2, bit 4 reserved
// [R14] bit 7 doubles the serial baud rate
// [R15] idle gates cpu clock only, watchdog halted too
// [R16] idle keeps all cpu state by gating its clock
// [R17] idle holds latch-driven pins, alternate functions keep driving
// [R18] idle forces address latch and code read strobes high
// [R19] idle needs arm then start on the next write; bits read zero
// [R20] power-down needs arm then start on the next write; bits read zero
// [R21] enabled interrupt or hardware reset ends idle
// [R22] power-down stops oscillator, only hardware reset ends it
// [R23] compare edges over repeated reference windows to catch a stopped oscillator
module osc_monitor_power_modes
  import osc_pm_pkg::*;
#(
  parameter int WIN_REF       = 4,
  parameter int SETTLE_CNT    = SETTLE_CYCLES,
  parameter int CNT_W         = 8
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // oscillator sense
  input  wire logic        osc_level,
  input  wire logic        rc_level,
  // reset sources and events
  input  wire logic        ext_reset,
  input  wire logic        wdt_timeout_evt,
  input  wire logic        irq_pending,
  // clock and reset control
  output logic             clk_sel_rc,
  output logic             osc_reset_req,
  output logic             chip_reset,
  output logic             wdt_stop,
  output logic             baud_double,
  output sleep_ctrl_t      sleep_ctrl,
  output logic [1:0]       spare_flags
);

  mon_state_t       mon_reg;
  pm_state_t        pm_reg;
  logic             osc_q, rc_q;
  logic [2:0]       div_reg;
  logic [CNT_W-1:0] win_reg;
  logic [CNT_W-1:0] osc_cnt_reg;
  logic [31:0]      settle_reg;
  logic             idle_arm_reg, deep_arm_reg;
  logic             spare_a_reg, spare_b_reg, baud_reg;
  logic             osc_flag_reg, tout_flag_reg;
  logic             osc_edge, ref_tick, win_end, win_fail;
  logic             apb_wr, wr_power_mode_control, wr_stat, mapped;
  logic             idle_go, deep_go;

  // edge detection on the sampled oscillator levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_q <= 1'b0;
      rc_q  <= 1'b0;
    end else begin
      osc_q <= osc_level;
      rc_q  <= rc_level;
    end
  end

  assign osc_edge = osc_level & ~osc_q;
  assign ref_tick = rc_level & ~rc_q & (div_reg == REF_DIV_LAST); // [R1]
  assign win_end  = ref_tick && (win_reg == CNT_W'(WIN_REF - 1));
  // equal counts pass: only a slower oscillator fails
  assign win_fail = (osc_cnt_reg < CNT_W'(WIN_REF)); // [R1]

  // rc divide-by-five and window counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg     <= 3'h0;
      win_reg     <= '0;
      osc_cnt_reg <= '0;
    end else begin
      if (rc_level && !rc_q) begin
        div_reg <= (div_reg == REF_DIV_LAST) ? 3'h0 : div_reg + 3'h1; // [R1]
      end
      // windows restart in power-down so a stale count cannot fail on wake-up
      if (win_end || pm_reg == PM_DOWN) begin
        win_reg     <= '0; // [R23] [R22]
        osc_cnt_reg <= '0;
      end else begin
        if (ref_tick) begin
          win_reg <= win_reg + CNT_W'(1);
        end
        if (osc_edge && osc_cnt_reg != '1) begin
          osc_cnt_reg <= osc_cnt_reg + CNT_W'(1);
        end
      end
    end
  end

  // monitor state: failure, settle, run; windows ignored in power-down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_reg    <= MON_FAIL; // [R9]
      settle_reg <= 32'h0;
    end else begin
      unique case (mon_reg)
        MON_FAIL: begin
          settle_reg <= 32'h0;
          if (win_end && !win_fail) begin
            mon_reg <= MON_SETTLE; // [R5]
          end
        end
        MON_SETTLE: begin
          settle_reg <= settle_reg + 32'h1;
          if (win_end && win_fail) begin
            mon_reg <= MON_FAIL;
          end else if (settle_reg == 32'(SETTLE_CNT - 1)) begin
            mon_reg <= MON_RUN; // [R6]
          end
        end
        MON_RUN: begin
          if (win_end && win_fail && pm_reg != PM_DOWN) begin
            mon_reg <= MON_FAIL; // [R2] [R3]
          end
        end
      endcase
    end
  end

  // clock select and reset requests
  assign clk_sel_rc    = (mon_reg != MON_RUN); // [R2] [R5]
  assign osc_reset_req = (mon_reg != MON_RUN); // [R3] [R5] [R6]
  assign chip_reset    = osc_reset_req | ext_reset; // [R7]
  assign wdt_stop      = osc_reset_req | (pm_reg != PM_ACTIVE); // [R4] [R15]

  // apb decode: zero wait states, unmapped address answers with an error
  assign apb_wr  = psel & penable & pwrite;
  assign mapped  = (paddr == POWER_MODE_CONTROL_ADDR) || (paddr == STAT_ADDR);
  assign wr_power_mode_control = apb_wr && (paddr == POWER_MODE_CONTROL_ADDR);
  assign wr_stat = apb_wr && (paddr == STAT_ADDR);
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~mapped;

  // read data captured in the setup phase; arm and start bits read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= 32'h0;
      if (paddr == POWER_MODE_CONTROL_ADDR) begin
        prdata[BAUD_BIT]    <= baud_reg; // [R14]
        prdata[SPARE_B_BIT] <= spare_b_reg; // [R13]
        prdata[SPARE_A_BIT] <= spare_a_reg; // [R13]
      end else if (paddr == STAT_ADDR) begin
        prdata[OSC_FLAG_BIT]  <= osc_flag_reg;
        prdata[TOUT_FLAG_BIT] <= tout_flag_reg;
        prdata[RC_SEL_BIT]    <= clk_sel_rc;
        prdata[OSC_RST_BIT]   <= osc_reset_req;
      end
    end
  end

  // start only counts when armed by the previous write and not re-armed now
  assign idle_go = wr_power_mode_control && pwdata[LIGHT_START_BIT] && !pwdata[IDLE_ARM_BIT]
                   && idle_arm_reg; // [R12] [R19]
  assign deep_go = wr_power_mode_control && pwdata[DEEP_START_BIT] && !pwdata[DEEP_ARM_BIT]
                   && deep_arm_reg; // [R11] [R20]

  // power-mode control register contents, cleared by any chip reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_arm_reg <= POWER_MODE_CONTROL_RESET[IDLE_ARM_BIT];
      deep_arm_reg <= POWER_MODE_CONTROL_RESET[DEEP_ARM_BIT];
      spare_a_reg  <= POWER_MODE_CONTROL_RESET[SPARE_A_BIT];
      spare_b_reg  <= POWER_MODE_CONTROL_RESET[SPARE_B_BIT];
      baud_reg     <= POWER_MODE_CONTROL_RESET[BAUD_BIT];
    end else if (chip_reset) begin
      idle_arm_reg <= POWER_MODE_CONTROL_RESET[IDLE_ARM_BIT];
      deep_arm_reg <= POWER_MODE_CONTROL_RESET[DEEP_ARM_BIT];
      spare_a_reg  <= POWER_MODE_CONTROL_RESET[SPARE_A_BIT];
      spare_b_reg  <= POWER_MODE_CONTROL_RESET[SPARE_B_BIT];
      baud_reg     <= POWER_MODE_CONTROL_RESET[BAUD_BIT];
    end else if (wr_power_mode_control) begin
      // concurrent arm and start never arms
      idle_arm_reg <= pwdata[IDLE_ARM_BIT] & ~pwdata[LIGHT_START_BIT]; // [R19]
      deep_arm_reg <= pwdata[DEEP_ARM_BIT] & ~pwdata[DEEP_START_BIT]; // [R20]
      spare_a_reg  <= pwdata[SPARE_A_BIT]; // [R13]
      spare_b_reg  <= pwdata[SPARE_B_BIT]; // [R13]
      baud_reg     <= pwdata[BAUD_BIT]; // [R14]
    end
  end

  assign baud_double = baud_reg; // [R14]
  assign spare_flags = {spare_b_reg, spare_a_reg};

  // power mode state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_reg <= PM_ACTIVE;
    end else if (chip_reset) begin
      pm_reg <= PM_ACTIVE; // [R21] [R22]
    end else begin
      unique case (pm_reg)
        PM_ACTIVE: begin
          if (deep_go) begin
            pm_reg <= PM_DOWN; // [R10] [R11]
          end else if (idle_go) begin
            pm_reg <= PM_IDLE; // [R12]
          end
        end
        PM_IDLE: begin
          if (irq_pending) begin
            pm_reg <= PM_ACTIVE; // [R21]
          end
        end
        PM_DOWN: begin
          pm_reg <= PM_DOWN; // [R22]
        end
      endcase
    end
  end

  // gating and pin control; cpu state kept because its clock simply stops
  always_comb begin
    sleep_ctrl.cpu_clk_en    = (pm_reg == PM_ACTIVE); // [R15] [R16]
    sleep_ctrl.periph_clk_en = (pm_reg != PM_DOWN); // [R15] [R22]
    sleep_ctrl.osc_run       = (pm_reg != PM_DOWN); // [R22]
    sleep_ctrl.port_hold     = (pm_reg != PM_ACTIVE); // [R17]
    sleep_ctrl.strobe_force  = (pm_reg != PM_ACTIVE); // [R18]
    sleep_ctrl.strobe_level  = (pm_reg == PM_IDLE); // [R18]
  end

  // reset cause flags; hardware set wins over software or external clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_flag_reg  <= 1'b0;
      tout_flag_reg <= 1'b0;
    end else begin
      if (osc_reset_req) begin
        osc_flag_reg <= 1'b1; // [R4]
      end else if (ext_reset) begin
        osc_flag_reg <= 1'b0; // [R8]
      end else if (wr_stat) begin
        osc_flag_reg <= pwdata[OSC_FLAG_BIT]; // [R8]
      end
      if (wdt_timeout_evt) begin
        tout_flag_reg <= 1'b1;
      end else if (ext_reset) begin
        tout_flag_reg <= 1'b0; // [R8] [R4]
      end else if (wr_stat) begin
        tout_flag_reg <= pwdata[TOUT_FLAG_BIT];
      end
    end
  end

  // helper: first cycle after reset release, settle length counter
  logic        first_q;
  logic [31:0] rc_hold_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_q     <= 1'b1;
      rc_hold_cnt <= 32'h0;
    end else begin
      first_q     <= 1'b0;
      rc_hold_cnt <= (mon_reg == MON_SETTLE) ? rc_hold_cnt + 32'h1 : 32'h0;
    end
  end

  sequence s_arm_idle;
    wr_power_mode_control && pwdata[IDLE_ARM_BIT] && !pwdata[LIGHT_START_BIT] && !chip_reset;
  endsequence

  sequence s_start_idle;
    wr_power_mode_control && pwdata[LIGHT_START_BIT] && !pwdata[IDLE_ARM_BIT]
      && !pwdata[DEEP_START_BIT] && !chip_reset && pm_reg == PM_ACTIVE;
  endsequence

  sequence s_both_bits;
    wr_power_mode_control && pwdata[IDLE_ARM_BIT] && pwdata[LIGHT_START_BIT] && !chip_reset
      && pm_reg == PM_ACTIVE;
  endsequence

  a_fail_to_rc: assert property (@(posedge pclk) disable iff (!presetn) // [R1] [R2] [R3]
    (mon_reg == MON_RUN && win_end && win_fail && pm_reg != PM_DOWN)
      |=> clk_sel_rc && osc_reset_req && chip_reset)
    else $error("failure did not select rc clock with reset");

  a_settle_len: assert property (@(posedge pclk) disable iff (!presetn) // [R5] [R6]
    $fell(osc_reset_req) |-> $past(mon_reg) == MON_SETTLE
      && $past(rc_hold_cnt) == 32'(SETTLE_CNT - 1))
    else $error("reset released before settle phase ended");

  a_ext_holds: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    ext_reset |-> chip_reset)
    else $error("chip left reset while external reset held");

  a_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    osc_reset_req && !wdt_timeout_evt && !ext_reset && !wr_stat && !first_q
      |-> wdt_stop ##1 (osc_flag_reg && tout_flag_reg == $past(tout_flag_reg)))
    else $error("monitor reset flag handling wrong");

  a_ext_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
    ext_reset && !osc_reset_req && !wdt_timeout_evt |=> !osc_flag_reg && !tout_flag_reg)
    else $error("external reset did not clear flags");

  a_power_on: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
    first_q |-> clk_sel_rc && chip_reset)
    else $error("no rc reset right after power-on");

  a_deep_wins: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    idle_go && deep_go && !chip_reset && pm_reg == PM_ACTIVE |=> pm_reg == PM_DOWN)
    else $error("idle taken over power-down");

  a_idle_seq: assert property (@(posedge pclk) disable iff (!presetn) // [R19] [R12]
    s_arm_idle ##1 (!wr_power_mode_control && !chip_reset)[*2] ##1 s_start_idle
      |=> pm_reg == PM_IDLE && !sleep_ctrl.cpu_clk_en && sleep_ctrl.strobe_level)
    else $error("armed idle start not taken");

  a_idle_both: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
    (s_both_bits and (!idle_arm_reg && !deep_go)) |=> pm_reg == PM_ACTIVE ##1 !idle_arm_reg)
    else $error("concurrent arm and start entered idle");

  a_idle_wake: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
    pm_reg == PM_IDLE && irq_pending |=> pm_reg == PM_ACTIVE)
    else $error("interrupt did not end idle");

  a_deep_stay: assert property (@(posedge pclk) disable iff (!presetn) // [R22]
    pm_reg == PM_DOWN && !chip_reset |=> pm_reg == PM_DOWN && !sleep_ctrl.osc_run)
    else $error("power-down left without reset");

  a_strobe_idle: assert property (@(posedge pclk) disable iff (!presetn) // [R18] [R17]
    pm_reg == PM_IDLE |-> sleep_ctrl.strobe_force && sleep_ctrl.strobe_level
      && sleep_ctrl.port_hold && sleep_ctrl.periph_clk_en)
    else $error("idle strobes not forced high");

endmodule

// File: osc_src_model.sv
// partner model: rc reference and crystal oscillator levels seen by the monitor
module osc_src_model (
  // clock and control
  input  wire logic       pclk,
  input  wire logic [7:0] osc_half,
  input  wire logic       osc_run,
  // sensed levels
  output logic            osc_level,
  output logic            rc_level
);
  timeunit 1ns;
  timeprecision 1ns;

  logic       rc_ph;
  logic [7:0] osc_cnt;

  // start-up levels
  initial begin
    rc_ph = 1'b0;
    rc_level = 1'b0;
    osc_level = 1'b0;
    osc_cnt = 8'h00;
  end

  // rc reference toggles every second cycle, stays below pclk/2
  always @(posedge pclk) begin
    rc_ph <= ~rc_ph;
    if (rc_ph) rc_level <= ~rc_level;
  end

  // crystal holds its level when stopped or switched off in power-down
  always @(posedge pclk) begin
    if (osc_half == 8'h00 || !osc_run) begin
      osc_cnt <= 8'h00;
    end else if (osc_cnt + 8'h01 >= osc_half) begin
      osc_cnt <= 8'h00;
      osc_level <= ~osc_level;
    end else begin
      osc_cnt <= osc_cnt + 8'h01;
    end
  end
endmodule

// File: testbench.sv
// self-checking bench: apb traffic, power modes and oscillator failure
module testbench;
  import osc_pm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int SETTLE = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v, seed;
  logic        osc_level, rc_level, ext_reset, wdt_timeout_evt, irq_pending;
  logic        clk_sel_rc, osc_reset_req, chip_reset, wdt_stop, baud_double;
  logic [1:0]  spare_flags;
  logic [7:0]  osc_half;
  sleep_ctrl_t sleep_ctrl;
  logic [32:0] exp_q[$];
  int          n_fail, n_checks, n;

  osc_monitor_power_modes #(.SETTLE_CNT(SETTLE)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .osc_level(osc_level), .rc_level(rc_level), .ext_reset(ext_reset),
    .wdt_timeout_evt(wdt_timeout_evt), .irq_pending(irq_pending),
    .clk_sel_rc(clk_sel_rc), .osc_reset_req(osc_reset_req), .chip_reset(chip_reset),
    .wdt_stop(wdt_stop), .baud_double(baud_double), .sleep_ctrl(sleep_ctrl),
    .spare_flags(spare_flags));

  osc_src_model u_src (.pclk(pclk), .osc_half(osc_half), .osc_run(sleep_ctrl.osc_run),
    .osc_level(osc_level), .rc_level(rc_level));

  // clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; expected {pslverr, read data} noted for the monitor
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int i;
    @(posedge pclk);
    exp_q.push_back(e);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin n_fail++; test_done(); end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // bounded wait for the monitor reset request to reach a level
  task automatic wait_req(input logic lvl, input int lim, output int cnt);
    for (cnt = 0; cnt < lim; cnt++) begin
      @(posedge pclk);
      #1;
      if (osc_reset_req === lvl) break;
    end
    if (cnt == lim) begin
      check(33'(osc_reset_req), 33'(lvl));
      test_done();
    end
  endtask

  // completed transfers compared against the oldest note
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (exp_q.size() == 0) check(33'h0, 33'h1);
      else check({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
    end
  end

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {ext_reset, wdt_timeout_evt, irq_pending, osc_half, n_fail, n_checks} = '0;
    seed = 32'h0000efaf;
    repeat (6) @(posedge pclk);
    #1 check({clk_sel_rc, chip_reset}, 33'h3);
    @(posedge pclk) presetn <= 1'b1;
    repeat (300) @(posedge pclk);
    #1 check({clk_sel_rc, osc_reset_req, chip_reset}, 33'h7);
    apb(1'b0, STAT_ADDR, 32'h0, 33'h0d);
    apb(1'b1, POWER_MODE_CONTROL_ADDR, 32'h84, 33'h0);
    apb(1'b0, POWER_MODE_CONTROL_ADDR, 32'h0, 33'h0);
    @(posedge pclk) osc_half <= 8'h02;
    wait_req(1'b0, 600, n);
    check(33'(n >= SETTLE), 33'h1);
    check({clk_sel_rc, chip_reset}, 33'h0);
    $display("test power_on done");
    for (int k = 0; k < 4; k++) begin
      v = xs() & 32'h9c;
      apb(1'b1, POWER_MODE_CONTROL_ADDR, v, 33'h0);
      apb(1'b0, POWER_MODE_CONTROL_ADDR, 32'h0, {1'b0, v & 32'h8c});
      check({baud_double, spare_flags}, {v[7], v[3], v[2]});
    end
    apb(1'b1, POWER_MODE_CONTROL_ADDR, 32'h63, 33'h0);
    apb(1'b1, POWER_MODE_CONTROL_ADDR, 32'h01, 33'h0);
    apb(1'b0, POWER_MODE_CONTROL_ADDR, 32'h0, 33'h0);
    apb(1'b1, POWER_MODE_CONTROL_ADDR, 32'h04, 33'h0);
    apb(1'b1, POWER_MODE_CONTROL_ADDR, 32'h20, 33'h0);
    @(posedge pclk);
    #1 check(sleep_ctrl, 33'h38);
    apb(1'b1, POWER_MODE_CONTROL_ADDR, 32'h42, 33'h0);
    @(posedge pclk);
    #1 check(sleep_ctrl, 33'h38);
    apb(1'b0, POWER_MODE_CONTROL_ADDR, 32'h0, 33'h0);
    apb(1'b0, 12'h000, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h004, 32'hff, {1'b1, 32'h0});
    apb(1'b1, STAT_ADDR, 32'h01, 33'h0);
    apb(1'b0, STAT_ADDR, 32'h0, 33'h01);
    apb(1'b1, STAT_ADDR, 32'h00, 33'h0);
    apb(1'b0, STAT_ADDR, 32'h0, 33'h00);
    $display("test registers done");
    apb(1'b1, POWER_MODE_CONTROL_ADDR, 32'h01, 33'h0);
    apb(1'b1, POWER_MODE_CONTROL_ADDR, 32'h20, 33'h0);
    @(posedge pclk);
    #1 check(sleep_ctrl, 33'h1f);
    check(wdt_stop, 33'h1);
    @(posedge pclk) irq_pending <= 1'b1;
    repeat (2) @(posedge pclk);
    #1 check(sleep_ctrl, 33'h38);
    @(posedge pclk) irq_pending <= 1'b0;
    $display("test idle done");
    apb(1'b1, POWER_MODE_CONTROL_ADDR, 32'h03, 33'h0);
    apb(1'b1, POWER_MODE_CONTROL_ADDR, 32'h60, 33'h0);
    @(posedge pclk);
    #1 check({sleep_ctrl.cpu_clk_en, sleep_ctrl.periph_clk_en, sleep_ctrl.osc_run,
              sleep_ctrl.strobe_force, sleep_ctrl.strobe_level}, 33'h02);
    @(posedge pclk) irq_pending <= 1'b1;
    repeat (200) @(posedge pclk);
    #1 check({sleep_ctrl.cpu_clk_en, osc_reset_req}, 33'h0);
    @(posedge pclk) begin irq_pending <= 1'b0; ext_reset <= 1'b1; end
    #1 check(chip_reset, 33'h1);
    repeat (3) @(posedge pclk);
    ext_reset <= 1'b0;
    repeat (2) @(posedge pclk);
    #1 check(sleep_ctrl, 33'h38);
    apb(1'b0, POWER_MODE_CONTROL_ADDR, 32'h0, 33'h0);
    wait_req(1'b0, 400, n);
    $display("test power_down done");
    @(posedge pclk) wdt_timeout_evt <= 1'b1;
    @(posedge pclk) wdt_timeout_evt <= 1'b0;
    apb(1'b0, STAT_ADDR, 32'h0, 33'h02);
    @(posedge pclk) osc_half <= 8'd20;
    wait_req(1'b1, 400, n);
    check({clk_sel_rc, chip_reset, wdt_stop}, 33'h7);
    apb(1'b0, STAT_ADDR, 32'h0, 33'h0f);
    @(posedge pclk) begin osc_half <= 8'h02; ext_reset <= 1'b1; end
    wait_req(1'b0, 600, n);
    check({clk_sel_rc, chip_reset}, 33'h1);
    @(posedge pclk) ext_reset <= 1'b0;
    @(posedge pclk);
    #1 check(chip_reset, 33'h0);
    apb(1'b0, STAT_ADDR, 32'h0, 33'h00);
    $display("test osc_fail done");
    test_done();
  end
endmodule
